/* File: hdl/odem_consts.vh */
/*
 * Constants for the overheat diode emulation controller.
 * Assumes inclusion by bare name from design and checker files.
 */
`ifndef ODEM_CONSTS_VH
`define ODEM_CONSTS_VH

// Clock period in picoseconds.
`define ODEM_CLK_PERIOD_PS 4000
// Falling edge blanking time in nanoseconds.
`define ODEM_BLANK_NS 200
// Blanking cycles; a least time rounds up.
`define ODEM_BLANK_CYCLES ((`ODEM_BLANK_NS * 1000 + `ODEM_CLK_PERIOD_PS - 1) / `ODEM_CLK_PERIOD_PS)
`define ODEM_BLANK_W 8
// State codes, one-hot.
`define ODEM_ST_BLANK 3'h1
`define ODEM_ST_WATCH 3'h2
`define ODEM_ST_CONDUCT 3'h4
`define ODEM_ST_W 3

`endif

/* File: hdl/odem_sync.v */
/*
 * Two flip-flop synchroniser for a bundle of asynchronous levels.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none

module odem_sync #(
    parameter WIDTH = 4
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage1;

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        stage1 <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end else begin
        stage1 <= async_in;
        sync_out <= stage1;
    end
end

endmodule // odem_sync

`default_nettype wire

/* File: hdl/odem_blank_timer.v */
/*
 * Blanking timer: restarts on each start pulse, pulses done on expiry.
 * Assumes one clock and the synchronised active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "odem_consts.vh"

module odem_blank_timer (
    input wire sys_clk,
    input wire rst_n,
    input wire start,
    output reg done
);

reg [`ODEM_BLANK_W-1:0] count;
reg running;
// The reload value is worked out at full integer width and then cut to the counter width.
wire [31:0] blank_load = `ODEM_BLANK_CYCLES - 1;

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        count <= {`ODEM_BLANK_W{1'b0}};
        running <= 1'b0;
        done <= 1'b0;
    end else if (start) begin
        // A new edge always restarts the whole interval.
        count <= blank_load[`ODEM_BLANK_W-1:0];
        running <= 1'b1;
        done <= 1'b0;
    end else if (running) begin
        if (count == {`ODEM_BLANK_W{1'b0}}) begin
            running <= 1'b0;
            done <= 1'b1;
        end else begin
            count <= count - 1'b1;
            done <= 1'b0;
        end
    end else begin
        done <= 1'b0;
    end
end

endmodule // odem_blank_timer

`default_nettype wire

/* File: hdl/odem_fsm.v */
/*
 * Overheat diode emulation controller: decides the gate command of the
 * power switch while the device is in overheat shutdown.
 * Assumes asynchronous comparator pins and command input, one 250 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "odem_consts.vh"

module odem_fsm (
    input wire sys_clk,
    input wire resetn,
    input wire overheat_shutdown,
    input wire switch_cmd,
    input wire drain_negative,
    input wire current_forward,
    output reg gate_on,
    output reg protect_alarm,
    output reg overheat_diode_emulation_active,
    output reg operational_diode_emulation_start,
    output reg [`ODEM_ST_W-1:0] state
);

localparam [`ODEM_ST_W-1:0] ST_BLANK = `ODEM_ST_BLANK;
localparam [`ODEM_ST_W-1:0] ST_WATCH = `ODEM_ST_WATCH;
localparam [`ODEM_ST_W-1:0] ST_CONDUCT = `ODEM_ST_CONDUCT;

////////////////////////////////////////////////////////////////////////////////

reg rst_meta;
reg rst_n;

always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        rst_meta <= 1'b0;
        rst_n <= 1'b0;
    end else begin
        rst_meta <= 1'b1;
        rst_n <= rst_meta;
    end
end

////////////////////////////////////////////////////////////////////////////////

wire [3:0] synced;
wire shut_s;
wire cmd_s;
wire neg_s;
wire fwd_s;

odem_sync #(
    .WIDTH(4)
) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({overheat_shutdown, switch_cmd, drain_negative, current_forward}),
    .sync_out(synced)
);

assign shut_s = synced[3];
assign cmd_s = synced[2];
assign neg_s = synced[1];
assign fwd_s = synced[0];

reg cmd_d;
reg shut_d;

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        cmd_d <= 1'b0;
        shut_d <= 1'b0;
    end else begin
        cmd_d <= cmd_s;
        shut_d <= shut_s;
    end
end

// Edge detectors look only at the second synchroniser stage.
wire cmd_fall = cmd_d & ~cmd_s;
wire shut_enter = shut_s & ~shut_d;
wire shut_leave = shut_d & ~shut_s;
wire blank_start = shut_s & cmd_fall;

////////////////////////////////////////////////////////////////////////////////

wire blank_done;

odem_blank_timer u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(blank_start),
    .done(blank_done)
);

////////////////////////////////////////////////////////////////////////////////

reg [`ODEM_ST_W-1:0] next_state;

always @* begin
    next_state = state;
    if (!shut_s) begin
        next_state = ST_WATCH;
    end else if (shut_enter) begin
        next_state = ST_WATCH;
    end else if (cmd_fall) begin
        next_state = ST_BLANK;
    end else begin
        case (state)
            ST_BLANK: begin
                // Only the timer or leaving shutdown ends blanking, so a missing drain swing cannot hang it.
                if (blank_done) begin
                    next_state = ST_WATCH;
                end
            end
            ST_WATCH: begin
                if (neg_s) begin
                    next_state = ST_CONDUCT;
                end
            end
            ST_CONDUCT: begin
                if (fwd_s) begin
                    next_state = ST_WATCH;
                end
            end
            default: begin
                next_state = ST_WATCH;
            end
        endcase
    end
end

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        state <= ST_WATCH;
        gate_on <= 1'b0;
        protect_alarm <= 1'b0;
        overheat_diode_emulation_active <= 1'b0;
        operational_diode_emulation_start <= 1'b0;
    end else begin
        state <= next_state;
        // Switch is on only in conduction; blanking and monitoring keep it off.
        gate_on <= shut_s & (next_state == ST_CONDUCT);
        protect_alarm <= shut_s;
        overheat_diode_emulation_active <= shut_s;
        operational_diode_emulation_start <= shut_leave;
    end
end

endmodule // odem_fsm

`default_nettype wire

/* File: tb/odem_ctl_model.sv */
/* Controller model: drives the command pin. Assumes tog is a one-cycle request. */
`timescale 1ns/1ps
`default_nettype none
module odem_ctl (
    input wire logic sys_clk,
    input wire logic tog,
    output logic switch_cmd
);
int n = 0;
// One high pulse of four cycles, so each request yields one falling edge.
always @(posedge sys_clk) begin
    n <= tog ? 4 : (n > 0 ? n - 1 : 0);
end
assign switch_cmd = n > 0;
endmodule // odem_ctl
`default_nettype wire

/* File: tb/odem_fsm_properties.sv */
/* Checker on odem_fsm ports. Assumes bind below, one clock. */
`timescale 1ns/1ps
`default_nettype none
`include "odem_consts.vh"
module odem_props (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic overheat_shutdown,
    input wire logic switch_cmd,
    input wire logic drain_negative,
    input wire logic current_forward,
    input wire logic gate_on,
    input wire logic protect_alarm,
    input wire logic overheat_diode_emulation_active,
    input wire logic operational_diode_emulation_start,
    input wire logic [`ODEM_ST_W-1:0] state
);
int blank_n;
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) blank_n <= 0;
    else blank_n <= (state == `ODEM_ST_BLANK) ? blank_n + 1 : 0;
end
default clocking @(posedge sys_clk); endclocking
default disable iff (!resetn);
chk_gate_state: assert property (gate_on == (state == `ODEM_ST_CONDUCT))
    else $error("gate and state disagree");
chk_active_alarm: assert property (overheat_diode_emulation_active == protect_alarm)
    else $error("active differs from alarm");
chk_alarm_rise: assert property ($rose(overheat_shutdown) ##1 overheat_shutdown[*3]
    |-> protect_alarm) else $error("alarm late");
chk_idle_watch: assert property (!protect_alarm && !$past(protect_alarm)
    |-> state == `ODEM_ST_WATCH && !gate_on) else $error("busy outside shutdown");
chk_start_pulse: assert property (operational_diode_emulation_start
    |=> !operational_diode_emulation_start) else $error("handoff pulse too long");
chk_fall_blank: assert property ($fell(switch_cmd) && protect_alarm ##1 protect_alarm[*3]
    |-> state == `ODEM_ST_BLANK) else $error("no blanking after fall");
chk_blank_exit: assert property ($past(state) == `ODEM_ST_BLANK && state != `ODEM_ST_BLANK
    && protect_alarm |-> state == `ODEM_ST_WATCH && blank_n >= 49) else $error("bad blank exit");
chk_conduct_cause: assert property ($rose(gate_on) |-> $past(drain_negative, 3))
    else $error("conduction without negative drain");
cover property (state == `ODEM_ST_BLANK);
cover property ($rose(gate_on));
cover property (operational_diode_emulation_start);
endmodule // odem_props
bind odem_fsm odem_props i_props (.sys_clk(sys_clk), .resetn(resetn),
    .overheat_shutdown(overheat_shutdown), .switch_cmd(switch_cmd),
    .drain_negative(drain_negative), .current_forward(current_forward), .gate_on(gate_on),
    .protect_alarm(protect_alarm), .overheat_diode_emulation_active(overheat_diode_emulation_active),
    .operational_diode_emulation_start(operational_diode_emulation_start), .state(state));
`default_nettype wire

/* File: tb/testbench.sv */
/* Bench for odem_fsm against a state model. Assumes design, model, checker compiled. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
logic sys_clk = 1'b0;
logic resetn = 1'b0;
logic shut = 1'b0;
logic neg = 1'b0;
logic fwd = 1'b0;
logic tog = 1'b0;
logic switch_cmd, gate_on, alarm, start, active;
int n_start = 0;
int m_exit = 0;
logic [2:0] state;
int bad_count = 0;
int n_compared = 0;
int cycles = 0;
int m_st = 2;
int k;
always #2 sys_clk = ~sys_clk;
odem_ctl i_ctl (.sys_clk(sys_clk), .tog(tog), .switch_cmd(switch_cmd));
odem_fsm i_dut (.sys_clk(sys_clk), .resetn(resetn), .overheat_shutdown(shut),
    .switch_cmd(switch_cmd), .drain_negative(neg), .current_forward(fwd), .gate_on(gate_on),
    .protect_alarm(alarm), .overheat_diode_emulation_active(active),
    .operational_diode_emulation_start(start), .state(state));
task stop_test;
    if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
task cyc(input int n);
    repeat (n) @(posedge sys_clk);
endtask
task cmp;
    n_compared++;
    if ({state, gate_on, alarm, active} !== {m_st[2:0], m_st == 4, shut, shut}) begin
        bad_count++;
        $display("BAD %0t %h %h", $time, {state, gate_on, alarm, active},
            {m_st[2:0], m_st == 4, shut, shut});
    end
endtask
// Each exit from shutdown must give exactly one handoff pulse.
task cmp_start;
    n_compared++;
    if (n_start != m_exit) begin
        bad_count++;
        $display("BAD %0t %h %h", $time, n_start, m_exit);
    end
endtask
always @(posedge sys_clk) begin
    if (start === 1'b1) n_start++;
end
// The model steps at once but is compared only once the inputs have settled, so each step waits six cycles.
task put(input logic s, input logic n, input logic f);
    if (!s && shut) m_exit++;
    shut <= s;
    neg <= n;
    fwd <= f;
    if (!s) m_st = 2;
    else if (m_st == 2 && n) m_st = 4;
    else if (m_st == 4 && f) m_st = 2;
    cyc(6);
    cmp();
endtask
task toggle;
    tog <= 1'b1;
    cyc(1);
    tog <= 1'b0;
endtask
always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
        bad_count++;
        stop_test();
    end
end
initial begin
    k = $urandom(32'ha437);
    cyc(12);
    resetn <= 1'b1;
    cyc(4);
    put(1, 0, 0);
    for (k = 0; k < 3 + $urandom % 4; k++) begin
        put(1, 1, 0);
        put(1, 0, 1);
        put(1, 0, 1'($urandom));
    end
    put(1, 1, 0);
    toggle();
    m_st = 1;
    cyc(10);
    cmp();
    cyc(25);
    toggle();
    cyc(45);
    cmp();
    m_st = 4;
    cyc(20);
    cmp();
    put(0, 0, 0);
    cyc(2);
    cmp_start();
    stop_test();
end
endmodule // testbench
`default_nettype wire
